// ===== pll_cfg_pkg.sv
// shared constants for the alternate pll setting and its parameter calculator
package pll_cfg_pkg;

  // printed register indices; byte address is four times the index
  localparam logic [7:0] ALT_A_INDEX = 8'h1d;
  localparam logic [7:0] ALT_B_INDEX = 8'h1e;
  localparam logic [7:0] ALT_C_INDEX = 8'h1f;
  localparam logic [7:0] ALT_A_ADDR  = {ALT_A_INDEX[5:0], 2'h0};
  localparam logic [7:0] ALT_B_ADDR  = {ALT_B_INDEX[5:0], 2'h0};
  localparam logic [7:0] ALT_C_ADDR  = {ALT_C_INDEX[5:0], 2'h0};

  // calculator and control registers
  localparam logic [7:0] RATIO_ADDR  = 8'h00;
  localparam logic [7:0] FIN_ADDR    = 8'h04;
  localparam logic [7:0] OUTDIV_ADDR = 8'h08;
  localparam logic [7:0] CTRL_ADDR   = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] FVCO_ADDR   = 8'h14;
  localparam logic [7:0] FOUT_ADDR   = 8'h18;

  // reset values
  localparam logic [7:0]  ALT_A_RESET  = 8'h40;
  localparam logic [7:0]  ALT_B_RESET  = 8'h02;
  localparam logic [7:0]  ALT_C_RESET  = 8'h08;
  localparam logic [11:0] MULT_RESET   = 12'h004;
  localparam logic [8:0]  REFDIV_RESET = 9'h001;
  localparam logic [17:0] FIN_RESET    = 18'h06978;
  localparam logic [6:0]  OUTDIV_RESET = 7'h01;

  // field positions
  localparam int REFDIV_LSB  = 16;
  localparam int CTRL_START  = 0;
  localparam int CTRL_APPLY  = 1;
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_VALID    = 2;
  localparam int ST_STANDBY  = 3;
  localparam int ST_BAND_LSB = 4;
  localparam int ST_P_LSB    = 6;
  localparam int ST_Q_LSB    = 9;
  localparam int ST_R_LSB    = 15;

  // derivation limits
  localparam int unsigned SHIFT_BASE  = 4;
  localparam int unsigned Q_MIN       = 16;
  localparam int unsigned Q_MAX       = 63;
  localparam int unsigned KHZ_PER_MHZ = 1000;
  localparam int unsigned VCO_MIN_MHZ = 80;
  localparam int unsigned VCO_MAX_MHZ = 230;
  localparam int unsigned BAND1_MHZ   = 125;
  localparam int unsigned BAND2_MHZ   = 150;
  localparam int unsigned BAND3_MHZ   = 175;
  localparam logic [31:0] VCO_MIN_KHZ = 32'(VCO_MIN_MHZ * KHZ_PER_MHZ);
  localparam logic [31:0] VCO_MAX_KHZ = 32'(VCO_MAX_MHZ * KHZ_PER_MHZ);
  localparam logic [31:0] BAND1_KHZ   = 32'(BAND1_MHZ * KHZ_PER_MHZ);
  localparam logic [31:0] BAND2_KHZ   = 32'(BAND2_MHZ * KHZ_PER_MHZ);
  localparam logic [31:0] BAND3_KHZ   = 32'(BAND3_MHZ * KHZ_PER_MHZ);

  // calculator sequence
  typedef enum logic [2:0] {
    CALC_IDLE,
    CALC_DIV_Q,
    CALC_DIV_VCO,
    CALC_DIV_OUT,
    CALC_CHECK
  } calc_state_t;

endpackage

// ===== seq_divider.sv
// iterative restoring divider, one quotient bit per enabled cycle
`timescale 1ns/1ns
module seq_divider #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quotient,
  output logic [W-1:0]      remainder
);
  localparam int CW = $clog2(W + 1);

  // shifting needs at least two bits
  if (W < 2) begin : g_bad_width
    $error("seq_divider width must be at least 2");
  end

  logic [CW-1:0] count;                                  // steps left
  wire  [W:0]    trial = {remainder, quotient[W-1]};     // shifted partial
  wire  [W:0]    diff  = trial - {1'b0, divisor};        // trial subtract
  wire           take  = ~diff[W];                       // divisor fits
  wire           last  = (count == CW'(1));              // final step

  // a zero divisor yields all ones, callers treat it as invalid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      count     <= '0;
      quotient  <= '0;
      remainder <= '0;
    end else if (clk_en) begin
      done <= busy && last;
      if (start && !busy) begin
        // a start while busy is ignored
        busy      <= 1'b1;
        count     <= CW'(W);
        quotient  <= dividend;
        remainder <= '0;
      end else if (busy) begin
        remainder <= take ? diff[W-1:0] : trial[W-1:0];
        quotient  <= {quotient[W-2:0], take};
        count     <= count - CW'(1);
        busy      <= !last;
      end
    end
  end
endmodule

// ===== pll_divider_config.sv
// alternate pll setting registers with fractional-divider parameter calculator
//
// Contract
// RULE1 - twenty-four-bit setting split over three bytes
// RULE2 - band code from oscillator frequency, resets 00
// RULE3 - host keeps setting fields in range
// RULE4 - output equals input over divider times ratio
// RULE5 - host picks divider 1-511, multiplier 1-4095
// RULE6 - host programs output divider 1 to 127
// RULE7 - oscillator equals input times multiplier over divider
// RULE8 - shift, quotient, remainder derived from ratio
// RULE9 - scaled multiplier; multiplier not below divider
// RULE10 - host plans oscillator 80-230, narrow ranges
// RULE11 - output divider zero means standby
// RULE12 - calculator flags out-of-range settings invalid
`timescale 1ns/1ns
module pll_divider_config #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [3:0]             alt_feedback_multiplier,
  output logic [8:0]             alt_fraction_remainder,
  output logic [5:0]             alt_integer_quotient,
  output logic [2:0]             alt_prescale_shift,
  output logic [1:0]             alt_oscillator_band,
  output logic [6:0]             out_divider,
  output logic                   out_standby,
  output logic                   calc_busy,
  output logic                   calc_valid
);
  // the map needs eight address bits
  if (ADDR_W < 8) begin : g_bad_addr
    $error("pll_divider_config needs at least 8 address bits");
  end

  // band code from oscillator frequency in kHz
  function automatic logic [1:0] band_of(input logic [31:0] fvco);
    if (fvco >= pll_cfg_pkg::BAND3_KHZ)      band_of = 2'h3;
    else if (fvco >= pll_cfg_pkg::BAND2_KHZ) band_of = 2'h2;
    else if (fvco >= pll_cfg_pkg::BAND1_KHZ) band_of = 2'h1;
    else                                     band_of = 2'h0;
  endfunction

  // ---------------- register storage
  logic [7:0]  alt_a;          // multiplier low nibble, remainder high
  logic [7:0]  alt_b;          // remainder low, quotient high
  logic [7:0]  alt_c;          // quotient low, shift, band
  logic [11:0] mult;           // requested feedback multiplier
  logic [8:0]  refdiv;         // requested reference divider
  logic [17:0] fin_khz;        // input frequency in kHz
  logic        auto_apply;     // copy valid results into the setting
  logic        calc_done;      // sticky until the next start

  // ---------------- calculator state
  pll_cfg_pkg::calc_state_t state;
  logic [11:0] lat_n;          // operands latched at start
  logic [8:0]  lat_m;
  logic [17:0] lat_fin;
  logic [6:0]  lat_pdiv;
  logic [15:0] q_res;          // full quotient before range check
  logic [8:0]  r_res;
  logic [31:0] fvco_res;
  logic [31:0] fout_res;
  logic        div_start;
  logic        res_valid;

  // ---------------- apb decode
  wire [7:0] addr8    = paddr[7:0];
  wire       setup    = psel && !penable;
  wire       wr_fire  = psel && penable && pready && pwrite;
  wire       hit_a    = (addr8 == pll_cfg_pkg::ALT_A_ADDR);
  wire       hit_b    = (addr8 == pll_cfg_pkg::ALT_B_ADDR);
  wire       hit_c    = (addr8 == pll_cfg_pkg::ALT_C_ADDR);
  wire       hit_rat  = (addr8 == pll_cfg_pkg::RATIO_ADDR);
  wire       hit_fin  = (addr8 == pll_cfg_pkg::FIN_ADDR);
  wire       hit_odiv = (addr8 == pll_cfg_pkg::OUTDIV_ADDR);
  wire       hit_ctrl = (addr8 == pll_cfg_pkg::CTRL_ADDR);
  wire       hit_stat = (addr8 == pll_cfg_pkg::STATUS_ADDR);
  wire       hit_fvco = (addr8 == pll_cfg_pkg::FVCO_ADDR);
  wire       hit_fout = (addr8 == pll_cfg_pkg::FOUT_ADDR);
  wire       hi_zero  = (ADDR_W == 8) || (paddr >> 8) == '0;
  wire       mapped   = hi_zero && (hit_a || hit_b || hit_c || hit_rat || hit_fin
                        || hit_odiv || hit_ctrl || hit_stat || hit_fvco || hit_fout);
  wire       wr_a     = wr_fire && hi_zero && hit_a;
  wire       wr_b     = wr_fire && hi_zero && hit_b;
  wire       wr_c     = wr_fire && hi_zero && hit_c;
  wire       wr_rat   = wr_fire && hi_zero && hit_rat;
  wire       wr_fin   = wr_fire && hi_zero && hit_fin;
  wire       wr_odiv  = wr_fire && hi_zero && hit_odiv;
  wire       wr_ctrl  = wr_fire && hi_zero && hit_ctrl;
  wire       start    = wr_ctrl && pwdata[pll_cfg_pkg::CTRL_START];

  // ---------------- ratio analysis, floor log2 of n over m
  logic [11:0] ratio_ge;       // bit i: m shifted by i still fits n
  for (genvar i = 0; i < 12; i++) begin : g_ratio
    assign ratio_ge[i] = (({12'h000, lat_m} << i) <= {9'h000, lat_n});
  end

  // highest set bit of the fit vector
  function automatic logic [3:0] top_bit(input logic [11:0] v);
    top_bit = 4'h0;
    for (int j = 0; j < 12; j++) begin
      if (v[j]) top_bit = 4'(j);
    end
  endfunction

  wire [3:0]  log_ratio = top_bit(ratio_ge);
  wire [2:0]  p_calc    = (log_ratio >= 4'(pll_cfg_pkg::SHIFT_BASE)) ? 3'h0 // RULE8
                          : 3'(pll_cfg_pkg::SHIFT_BASE - 32'(log_ratio));
  wire [15:0] n_scaled  = {4'h0, lat_n} << p_calc;                          // RULE9
  wire [29:0] fin_x_n   = 30'(lat_fin * lat_n);                             // RULE7

  // ---------------- shared divider operand selection
  wire        sel_q    = (state == pll_cfg_pkg::CALC_DIV_Q);
  wire        sel_vco  = (state == pll_cfg_pkg::CALC_DIV_VCO);
  wire [31:0] div_num  = sel_q ? {16'h0000, n_scaled}                       // RULE8
                         : sel_vco ? {2'h0, fin_x_n}                        // RULE7
                         : fvco_res;                                        // RULE4
  wire [31:0] div_den  = (sel_q || sel_vco) ? {23'h0, lat_m} : {25'h0, lat_pdiv};
  wire [31:0] div_quo;
  wire [31:0] div_rem;
  wire        div_done;

  seq_divider #(.W(32)) u_div (
    .clk       (pclk),
    .rst_n     (presetn),
    .clk_en    (clk_en),
    .start     (div_start),
    .dividend  (div_num),
    .divisor   (div_den),
    .busy      (),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  // ---------------- validity of the derived setting
  wire vco_ok   = (fvco_res >= pll_cfg_pkg::VCO_MIN_KHZ)
                  && (fvco_res <= pll_cfg_pkg::VCO_MAX_KHZ);
  wire q_ok     = (q_res >= 16'(pll_cfg_pkg::Q_MIN)) && (q_res <= 16'(pll_cfg_pkg::Q_MAX));
  wire ratio_ok = (lat_m != '0) && (lat_n != '0) && (lat_n >= {3'h0, lat_m});
  wire next_val = ratio_ok && q_ok && vco_ok;                              // RULE12
  wire [1:0] calc_band = band_of(fvco_res);                                 // RULE2

  // ---------------- calculator sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= pll_cfg_pkg::CALC_IDLE;
      div_start <= 1'b0;
      calc_done <= 1'b0;
      res_valid <= 1'b0;
      lat_n     <= '0;
      lat_m     <= '0;
      lat_fin   <= '0;
      lat_pdiv  <= '0;
      q_res     <= '0;
      r_res     <= '0;
      fvco_res  <= '0;
      fout_res  <= '0;
    end else if (clk_en) begin
      div_start <= 1'b0;
      case (state)
        pll_cfg_pkg::CALC_IDLE: begin
          // new start clears the sticky done flag
          if (start) begin
            lat_n     <= mult;
            lat_m     <= refdiv;
            lat_fin   <= fin_khz;
            lat_pdiv  <= out_divider;
            calc_done <= 1'b0;
            div_start <= 1'b1;
            state     <= pll_cfg_pkg::CALC_DIV_Q;
          end
        end
        pll_cfg_pkg::CALC_DIV_Q: begin
          if (div_done) begin
            q_res     <= div_quo[15:0];                                    // RULE8
            r_res     <= div_rem[8:0];                                     // RULE8
            div_start <= 1'b1;
            state     <= pll_cfg_pkg::CALC_DIV_VCO;
          end
        end
        pll_cfg_pkg::CALC_DIV_VCO: begin
          if (div_done) begin
            fvco_res <= div_quo;                                           // RULE7
            if (lat_pdiv == '0) begin
              // standby divider, nothing to divide
              fout_res <= '0;                                              // RULE11
              state    <= pll_cfg_pkg::CALC_CHECK;
            end else begin
              div_start <= 1'b1;
              state     <= pll_cfg_pkg::CALC_DIV_OUT;
            end
          end
        end
        pll_cfg_pkg::CALC_DIV_OUT: begin
          if (div_done) begin
            fout_res <= div_quo;                                           // RULE4
            state    <= pll_cfg_pkg::CALC_CHECK;
          end
        end
        pll_cfg_pkg::CALC_CHECK: begin
          res_valid <= next_val;                                           // RULE12
          calc_done <= 1'b1;
          state     <= pll_cfg_pkg::CALC_IDLE;
        end
        default: state <= pll_cfg_pkg::CALC_IDLE;
      endcase
    end
  end

  // ---------------- setting bytes: bus write wins over an apply in the same cycle
  wire apply = (state == pll_cfg_pkg::CALC_CHECK) && next_val && auto_apply;
  wire [7:0] next_alt_a = wr_a ? pwdata[7:0]
                          : apply ? {lat_n[3:0], r_res[8:5]} : alt_a;      // RULE1
  wire [7:0] next_alt_b = wr_b ? pwdata[7:0]
                          : apply ? {r_res[4:0], q_res[5:3]} : alt_b;      // RULE1
  wire [7:0] next_alt_c = wr_c ? pwdata[7:0]
                          : apply ? {q_res[2:0], p_calc, calc_band} : alt_c; // RULE1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_a <= pll_cfg_pkg::ALT_A_RESET;
      alt_b <= pll_cfg_pkg::ALT_B_RESET;
      alt_c <= pll_cfg_pkg::ALT_C_RESET;                                   // RULE2
    end else if (clk_en) begin
      alt_a <= next_alt_a;
      alt_b <= next_alt_b;
      alt_c <= next_alt_c;
    end
  end

  // ---------------- calculator inputs and control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult        <= pll_cfg_pkg::MULT_RESET;
      refdiv      <= pll_cfg_pkg::REFDIV_RESET;
      fin_khz     <= pll_cfg_pkg::FIN_RESET;
      out_divider <= pll_cfg_pkg::OUTDIV_RESET;
      auto_apply  <= 1'b0;
    end else if (clk_en) begin
      if (wr_rat) begin
        mult   <= pwdata[11:0];
        refdiv <= pwdata[pll_cfg_pkg::REFDIV_LSB +: 9];
      end
      if (wr_fin)  fin_khz     <= pwdata[17:0];
      if (wr_odiv) out_divider <= pwdata[6:0];
      if (wr_ctrl) auto_apply  <= pwdata[pll_cfg_pkg::CTRL_APPLY];
    end
  end

  // ---------------- read mux, sampled in the setup cycle
  wire [31:0] status_word = {8'h00, r_res, q_res[5:0], p_calc, calc_band,
                             out_standby, res_valid, calc_done, calc_busy};
  wire [31:0] rd_value =
      hit_a    ? {24'h0, alt_a} :
      hit_b    ? {24'h0, alt_b} :
      hit_c    ? {24'h0, alt_c} :
      hit_rat  ? {7'h00, refdiv, 4'h0, mult} :
      hit_fin  ? {14'h0000, fin_khz} :
      hit_odiv ? {25'h0, out_divider} :
      hit_ctrl ? {30'h0, auto_apply, 1'b0} :
      hit_stat ? status_word :
      hit_fvco ? fvco_res :
      hit_fout ? fout_res : 32'h0;

  // one wait-free access phase; pready and data come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && mapped && !pwrite) ? rd_value : 32'h0;
    end
  end

  // ---------------- flopped status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_standby <= 1'b0;
      calc_busy   <= 1'b0;
      calc_valid  <= 1'b0;
    end else if (clk_en) begin
      out_standby <= (out_divider == '0);                                  // RULE11
      calc_busy   <= (state != pll_cfg_pkg::CALC_IDLE) || start;
      calc_valid  <= res_valid;
    end
  end

  // setting fields drive straight from the byte flops
  assign alt_feedback_multiplier = alt_a[7:4];                             // RULE1
  assign alt_fraction_remainder  = {alt_a[3:0], alt_b[7:3]};               // RULE1
  assign alt_integer_quotient    = {alt_b[2:0], alt_c[7:5]};               // RULE1
  assign alt_prescale_shift      = alt_c[4:2];                             // RULE1
  assign alt_oscillator_band     = alt_c[1:0];                             // RULE2

  // ---------------- checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire at_check = (state == pll_cfg_pkg::CALC_CHECK);
  wire [63:0] vco_lo = 64'(fvco_res) * 64'(lat_m);
  wire [63:0] vco_hi = (64'(fvco_res) + 64'h1) * 64'(lat_m);
  wire [63:0] out_lo = 64'(fout_res) * 64'(lat_pdiv);
  wire [63:0] out_hi = (64'(fout_res) + 64'h1) * 64'(lat_pdiv);
  wire [31:0] q_x_m  = 32'(q_res) * 32'(lat_m) + 32'(r_res);

  a_byte_c_layout: assert property (clk_en && wr_c |=> // RULE1
    alt_prescale_shift == $past(pwdata[4:2]) && alt_integer_quotient[2:0] == $past(pwdata[7:5]))
    else $error("setting byte c fields misplaced");
  a_apply_band: assert property (clk_en && apply && !wr_c |=> // RULE2
    alt_oscillator_band == $past(calc_band) && alt_prescale_shift == $past(p_calc))
    else $error("applied band or shift wrong");
  a_fout_relation: assert property (at_check && lat_pdiv != '0 |-> // RULE4
    out_lo <= 64'(fvco_res) && out_hi > 64'(fvco_res))
    else $error("output frequency not oscillator over divider");
  a_fvco_relation: assert property (at_check && lat_m != '0 |-> // RULE7
    vco_lo <= 64'(fin_x_n) && vco_hi > 64'(fin_x_n))
    else $error("oscillator frequency not input times ratio");
  a_quot_rem_pair: assert property (at_check && lat_m != '0 |-> // RULE8
    q_x_m == 32'(n_scaled) && r_res < lat_m)
    else $error("quotient and remainder do not rebuild scaled multiplier");
  a_shift_scaled: assert property (at_check && ratio_ok |-> // RULE9
    n_scaled >= 16'(lat_n) && (n_scaled >> p_calc) == 16'(lat_n) && p_calc <= 3'h4)
    else $error("scaled multiplier or shift wrong");
  a_standby_zero: assert property (clk_en && out_divider == '0 |=> out_standby) // RULE11
    else $error("zero output divider not in standby");
  a_valid_range: assert property (clk_en && at_check |=> // RULE12
    calc_done && (res_valid == $past(ratio_ok && q_ok && vco_ok)))
    else $error("validity flag disagrees with ranges");

  c_valid_calc:   cover property (clk_en && at_check && next_val);
  c_invalid_calc: cover property (clk_en && at_check && !next_val);
  c_standby_calc: cover property (clk_en && at_check && lat_pdiv == '0);
  c_apply_done:   cover property (clk_en && apply);
endmodule

// ===== cfg_host.sv
// apb requester standing in for the configuring host
`timescale 1ns/1ns
module cfg_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer: setup, access held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed; only the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines do not keep their last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== pll_divider_config_tb.sv
// self-checking bench for the alternate pll setting and calculator
`timescale 1ns/1ns
module pll_divider_config_tb;
  logic        pclk = 1'b0;     // bus clock
  logic        presetn = 1'b0;  // async reset
  logic        clk_en = 1'b1;   // run enable
  logic        psel, penable, pwrite, pready, pslverr;
  logic        out_standby, calc_busy, calc_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  mult;
  logic [8:0]  rem;
  logic [5:0]  quo;
  logic [2:0]  shf;
  logic [1:0]  band;
  logic [6:0]  odiv;
  logic        er;
  logic [31:0] seed = 32'hc9a9;  // xorshift state
  int          fails = 0;
  int          checks = 0;
  int          fx_n[4] = '{4, 11, 3, 4095};  // fixed worked ratios
  int          fx_m[4] = '{1, 2, 5, 1};

  // half period 5 ns
  always #5 pclk = ~pclk;

  pll_divider_config u_pll_divider_config (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alt_feedback_multiplier(mult),
    .alt_fraction_remainder(rem), .alt_integer_quotient(quo), .alt_prescale_shift(shf),
    .alt_oscillator_band(band), .out_divider(odiv), .out_standby(out_standby),
    .calc_busy(calc_busy), .calc_valid(calc_valid));
  cfg_host u_cfg_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // flags go through the word compare, unknowns still mismatch
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_reg(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_cfg_host.xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    u_cfg_host.xfer(1'b0, a, 32'h0, rd, er);
    chk_reg(what, exp, rd);
  endtask

  // model the calculator from integers, run it, compare every result except the status r, q, p and band of invalid runs
  task automatic run_calc(input int n, input int m, input int fin, input int pd, input bit ap);
    int k, p, q, r, fv, fo, bd, ok;
    logic [23:0] prev, expf;
    k = 0;
    while ((m << (k + 1)) <= n) k++;
    p = (k > 4) ? 0 : 4 - k;
    q = (n << p) / m;
    r = (n << p) - m * q;
    fv = int'(longint'(fin) * n / m);
    fo = (pd == 0) ? 0 : fv / pd;
    bd = (fv < 125000) ? 0 : (fv < 150000) ? 1 : (fv < 175000) ? 2 : 3;
    ok = int'(n >= m && q >= 16 && q <= 63 && fv >= 80000 && fv <= 230000);
    prev = {mult, rem, quo, shf, band};
    // setting bytes change only for a valid result with apply on
    expf = (ok != 0 && ap) ? {n[3:0], r[8:0], q[5:0], p[2:0], bd[1:0]} : prev;
    wr(pll_cfg_pkg::RATIO_ADDR, (32'(m) << 16) | 32'(n));
    wr(pll_cfg_pkg::FIN_ADDR, 32'(fin));
    wr(pll_cfg_pkg::OUTDIV_ADDR, 32'(pd));
    wr(pll_cfg_pkg::CTRL_ADDR, {30'h0, ap, 1'b1});
    #1;
    chk_bit("busy", 1'b1, calc_busy);
    chk_reg("out divider", 32'(pd), {25'h0, odiv});
    // freeze longer than a whole calculation; busy must survive it
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (200) @(posedge pclk);
    clk_en <= 1'b1;
    #1;
    chk_bit("frozen busy", 1'b1, calc_busy);
    rdc("ctrl", pll_cfg_pkg::CTRL_ADDR, {30'h0, ap, 1'b0});
    k = 0;
    // poll for done, bounded
    do begin
      u_cfg_host.xfer(1'b0, pll_cfg_pkg::STATUS_ADDR, 32'h0, rd, er);
      k++;
    end while (rd[pll_cfg_pkg::ST_DONE] !== 1'b1 && k < 200);
    chk_bit("done", 1'b1, rd[pll_cfg_pkg::ST_DONE]);
    chk_bit("valid", ok[0], rd[pll_cfg_pkg::ST_VALID]);
    if (ok != 0) begin
      chk_reg("status", {12'h0, r[8:0], q[5:0], p[2:0], bd[1:0]}, {12'h0, rd[23:4]});
    end
    rdc("vco", pll_cfg_pkg::FVCO_ADDR, 32'(fv));
    rdc("fout", pll_cfg_pkg::FOUT_ADDR, 32'(fo));
    chk_bit("standby", pd == 0, out_standby);
    chk_bit("valid flag", ok[0], calc_valid);
    chk_reg("fields", {8'h0, expf}, {8'h0, mult, rem, quo, shf, band});
  endtask

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog, well past the expected run of a few thousand cycles
  initial begin
    #500000;
    fails++;
    close_out();
  end

  // main sequence
  initial begin
    logic [7:0] a, b, c;
    int n, m;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset setting: n 4, r 0, q 16, p 2, band 0
    chk_reg("reset fields", 32'h00400208, {8'h0, mult, rem, quo, shf, band});
    rdc("byte a", pll_cfg_pkg::ALT_A_ADDR, 32'h40);
    rdc("byte c", pll_cfg_pkg::ALT_C_ADDR, 32'h08);
    a = 8'(rnd());
    b = 8'(rnd());
    c = 8'(rnd());
    wr(pll_cfg_pkg::ALT_A_ADDR, {24'h0, a});
    wr(pll_cfg_pkg::ALT_B_ADDR, {24'h0, b});
    wr(pll_cfg_pkg::ALT_C_ADDR, {24'h0, c});
    #1;
    chk_reg("written fields", {8'h0, a, b, c}, {8'h0, mult, rem, quo, shf, band});
    rdc("byte b", pll_cfg_pkg::ALT_B_ADDR, {24'h0, b});
    rdc("unmapped", 8'h20, 32'h0);
    chk_bit("unmapped err", 1'b1, er);
    wr(pll_cfg_pkg::STATUS_ADDR, 32'hffffffff);
    chk_bit("status write err", 1'b0, er);
    for (int i = 0; i < 24; i++) begin
      if (i < 4) begin
        run_calc(fx_n[i], fx_m[i], 27000, (i == 3) ? 0 : 2, 1'b1);
      end else begin
        m = 1 + int'(rnd() % 32'd64);
        n = m * (1 + int'(rnd() % 32'd16)) + int'(rnd() % 32'(m));
        run_calc(n, m, 8000 + int'(rnd() % 32'd24000), int'(rnd() % 32'd128), 1'(rnd()));
      end
    end
    close_out();
  end
endmodule
